// File: inc/rcip_map.svh
`ifndef RCIP_MAP_SVH
`define RCIP_MAP_SVH

// register bus
`define RCIP_ADDR_W 8
`define RCIP_OFS_CTRL 8'h00
`define RCIP_OFS_IRQ_CTRL 8'h04
`define RCIP_OFS_CCR 8'h08
`define RCIP_OFS_PIN_STAT 8'h0c
`define RCIP_OFS_EVT_STAT 8'h10
`define RCIP_OFS_EVT_MASK 8'h14
`define RCIP_RESP_OKAY 2'h0
`define RCIP_RESP_SLVERR 2'h2

// control register fields
`define RCIP_CTRL_BUS_CLOCK_OUT_EN 0
`define RCIP_CTRL_STOP 1
`define RCIP_CTRL_STR_LO 4
`define RCIP_CTRL_STR_HI 5
`define RCIP_IRQC_EDGE 0
`define RCIP_CCR_IMASK 0

// event bits, shared by status and mask
`define RCIP_EVT_IRQ_FALL 0
`define RCIP_EVT_WATCHDOG 1
`define RCIP_EVT_CLK_MON 2
`define RCIP_EVT_EXT_RST 3

// reset values
`define RCIP_RST_STOP 1'h0
`define RCIP_RST_STRETCH 2'h0
`define RCIP_RST_EDGE_SEL 1'h0
`define RCIP_RST_IMASK 1'h1
`define RCIP_RST_EVT_MASK 4'h0

// reset pin timing, in clk_sys cycles
`define RCIP_DRIVE_CYCLES 5'h10
`define RCIP_SAMPLE_DELAY 5'h08

`endif

// File: inc/rcip_pkg.sv
`include "rcip_map.svh"

package rcip_pkg;

    typedef enum logic [1:0] {
        mode_normal_single,
        mode_special_single,
        mode_special_periph,
        mode_expanded
    } op_mode_t;

    typedef enum logic [1:0] {
        rst_idle,
        rst_drive,
        rst_wait,
        rst_hold
    } rst_seq_t;

    typedef enum logic [1:0] {
        vec_external,
        vec_watchdog,
        vec_clock_monitor
    } vector_t;

    typedef struct packed {
        logic awvalid;
        logic [`RCIP_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`RCIP_ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic [2:0] irq_sync;
        logic irq_level;
        logic irq_edge_latch;
        logic irq_request;
        logic [2:0] bus_clock_out_sync;
        logic bus_clock_out_level;
        logic [2:0] rpin_sync;
        logic rpin_level;
        logic strap_done;
        op_mode_t mode;
        logic bus_clk_en;
        logic stop;
        logic [1:0] stretch;
        logic edge_sel;
        logic imask;
        logic [3:0] evt_status;
        logic [3:0] evt_mask;
        logic irq_out;
        logic e_phase;
        logic [2:0] stretch_cnt;
        logic bus_clock_out;
        logic bus_clock_oe;
        logic bus_cycle;
        rst_seq_t rseq;
        logic [4:0] rcnt;
        vector_t vec;
        vector_t src;
        logic reset_pin_out;
        logic reset_pin_oe;
        logic aw_got;
        logic w_got;
        logic [`RCIP_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        axil_rsp_t rsp;
    } rcip_state_t;

endpackage : rcip_pkg

// File: rtl/reset_clock_irq_pin_control.sv
// Notes on behaviour
// - clocks come from the input clock except in special peripheral mode; bus clock is half its rate.
// - normal single-chip mode: bus clock pin off after reset, software may enable.
// - special single-chip mode: bus clock pin on after reset, software may disable.
// - special peripheral mode: bus clock pin is an input driven externally.
// - stop mode halts the bus clock and its output, except in special peripheral mode.
// - bus clock cycles may be stretched for slow external accesses.
// - reset entry from the pin is asynchronous, release is synchronous to the clock.
// - watchdog or clock monitor failure pulls reset pin low, open drain.
// - internal reset drives pin low 16 cycles, samples it 8 later.
// - pin high picks the failure vector; pin low picks external reset vector.
// - maskable interrupt pin triggers on falling edge or low level, selectable.
// - interrupt pin is level sensitive after reset.
// - interrupt mask bit is set at reset, blocking pin requests.
// - interrupt pin is input only and always readable.
`timescale 1ns/1ps
`include "rcip_map.svh"

module reset_clock_irq_pin_control (
    // clock and reset; clk_sys is the external clock input
    input wire logic clk_sys,
    input wire logic rst_b,
    // register bus
    input wire rcip_pkg::axil_req_t axil_req,
    output rcip_pkg::axil_rsp_t axil_rsp,
    // operating mode strap
    input wire logic [1:0] mode_strap,
    // bus clock pin
    input wire logic bus_clock_in,
    output logic bus_clock_out,
    output logic bus_clock_oe,
    input wire logic ext_access,
    output logic bus_cycle,
    // reset pin and core reset
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic core_reset_b,
    output rcip_pkg::vector_t reset_vector_sel,
    // failure detectors
    input wire logic watchdog_fail,
    input wire logic clock_monitor_fail,
    // maskable interrupt pin
    input wire logic irq_pin_in,
    input wire logic irq_ack,
    output logic irq_request,
    // interrupt
    output logic irq_out
);
    import rcip_pkg::*;

    rcip_state_t s_q;
    rcip_state_t s_d;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic rd_fire;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] old_w;
    logic [31:0] new_w;
    logic [31:0] rd_w;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic irq_fall;
    logic e_fall;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] wr_v,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wr_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    function automatic logic is_mapped(input logic [`RCIP_ADDR_W-1:0] a);
        return (a == `RCIP_OFS_CTRL) || (a == `RCIP_OFS_IRQ_CTRL)
            || (a == `RCIP_OFS_CCR) || (a == `RCIP_OFS_PIN_STAT)
            || (a == `RCIP_OFS_EVT_STAT) || (a == `RCIP_OFS_EVT_MASK);
    endfunction : is_mapped

    function automatic logic [31:0] reg_word(
        input rcip_state_t st,
        input logic [`RCIP_ADDR_W-1:0] a
    );
        logic [31:0] w;
        w = 32'h0;
        case (a)
            `RCIP_OFS_CTRL: begin
                w[`RCIP_CTRL_BUS_CLOCK_OUT_EN] = st.bus_clk_en;
                w[`RCIP_CTRL_STOP] = st.stop;
                w[`RCIP_CTRL_STR_HI:`RCIP_CTRL_STR_LO] = st.stretch;
            end
            `RCIP_OFS_IRQ_CTRL: w[`RCIP_IRQC_EDGE] = st.edge_sel;
            `RCIP_OFS_CCR: w[`RCIP_CCR_IMASK] = st.imask;
            `RCIP_OFS_PIN_STAT: begin
                w[0] = st.irq_level;
                w[1] = st.rpin_level;
                w[3:2] = st.vec;
                w[5:4] = st.mode;
                w[6] = st.irq_request;
            end
            `RCIP_OFS_EVT_STAT: w[3:0] = st.evt_status;
            `RCIP_OFS_EVT_MASK: w[3:0] = st.evt_mask;
            default: w = 32'h0;
        endcase
        return w;
    endfunction : reg_word

    always_comb begin
        s_d = s_q;
        ev_set = 4'h0;
        ev_clr = 4'h0;
        old_w = 32'h0;
        new_w = 32'h0;
        rd_w = 32'h0;

        // pin synchronisers: a change counts once stages two and three agree
        s_d.irq_sync = {s_q.irq_sync[1:0], irq_pin_in};
        s_d.bus_clock_out_sync = {s_q.bus_clock_out_sync[1:0], bus_clock_in};
        s_d.rpin_sync = {s_q.rpin_sync[1:0], reset_pin_in};
        if (s_q.irq_sync[1] == s_q.irq_sync[2]) begin
            s_d.irq_level = s_q.irq_sync[2];
        end
        if (s_q.bus_clock_out_sync[1] == s_q.bus_clock_out_sync[2]) begin
            s_d.bus_clock_out_level = s_q.bus_clock_out_sync[2];
        end
        if (s_q.rpin_sync[1] == s_q.rpin_sync[2]) begin
            s_d.rpin_level = s_q.rpin_sync[2];
        end

        // mode strap is taken once, the first cycle after reset release
        if (!s_q.strap_done) begin
            s_d.strap_done = 1'b1;
            s_d.mode = op_mode_t'(mode_strap);
            case (op_mode_t'(mode_strap))
                mode_normal_single: s_d.bus_clk_en = 1'b0;
                mode_special_single: s_d.bus_clk_en = 1'b1;
                mode_special_periph: s_d.bus_clk_en = 1'b0;
                default: s_d.bus_clk_en = 1'b1;
            endcase
        end

        // register writes
        aw_take = axil_req.awvalid && s_q.rsp.awready;
        w_take = axil_req.wvalid && s_q.rsp.wready;
        if (aw_take) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = axil_req.awaddr;
        end
        if (w_take) begin
            s_d.w_got = 1'b1;
            s_d.wdata = axil_req.wdata;
            s_d.wstrb = axil_req.wstrb;
        end
        wr_fire = s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid;
        wr_hit = is_mapped(s_q.awaddr);
        if (wr_fire) begin
            old_w = reg_word(s_q, s_q.awaddr);
            new_w = merge_bytes(old_w, s_q.wdata, s_q.wstrb);
            case (s_q.awaddr)
                `RCIP_OFS_CTRL: begin
                    s_d.bus_clk_en = new_w[`RCIP_CTRL_BUS_CLOCK_OUT_EN];
                    s_d.stop = new_w[`RCIP_CTRL_STOP];
                    s_d.stretch = new_w[`RCIP_CTRL_STR_HI:`RCIP_CTRL_STR_LO];
                end
                `RCIP_OFS_IRQ_CTRL: s_d.edge_sel = new_w[`RCIP_IRQC_EDGE];
                `RCIP_OFS_CCR: s_d.imask = new_w[`RCIP_CCR_IMASK];
                `RCIP_OFS_EVT_MASK: s_d.evt_mask = new_w[3:0];
                default: s_d.evt_mask = s_d.evt_mask;
            endcase
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = wr_hit ? `RCIP_RESP_OKAY : `RCIP_RESP_SLVERR;
        end
        if (s_q.rsp.bvalid && axil_req.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
        s_d.rsp.wready = !s_d.w_got && !s_d.rsp.bvalid;

        // register reads; the event status clears on read
        rd_fire = axil_req.arvalid && s_q.rsp.arready;
        rd_hit = is_mapped(axil_req.araddr);
        if (rd_fire) begin
            rd_w = reg_word(s_q, axil_req.araddr);
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata = rd_w;
            s_d.rsp.rresp = rd_hit ? `RCIP_RESP_OKAY : `RCIP_RESP_SLVERR;
            if (axil_req.araddr == `RCIP_OFS_EVT_STAT) begin
                ev_clr = s_q.evt_status;
            end
        end
        if (s_q.rsp.rvalid && axil_req.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // bus clock: a toggle per clk_sys gives half the input rate
        e_fall = 1'b0;
        s_d.bus_cycle = 1'b0;
        if (s_q.mode == mode_special_periph) begin
            s_d.bus_clock_oe = 1'b0;
            s_d.bus_clock_out = 1'b0;
            s_d.stretch_cnt = 3'h0;
            s_d.e_phase = s_q.bus_clock_out_level;
            e_fall = s_q.e_phase && !s_q.bus_clock_out_level;
        end else if (s_q.stop) begin
            s_d.e_phase = 1'b0;
            s_d.stretch_cnt = 3'h0;
            s_d.bus_clock_out = 1'b0;
            s_d.bus_clock_oe = s_q.bus_clk_en;
        end else begin
            if (!s_q.e_phase) begin
                s_d.e_phase = 1'b1;
                // each stretch step adds one whole bus clock period
                if (ext_access) begin
                    s_d.stretch_cnt = {s_q.stretch, 1'b0};
                end
            end else if (s_q.stretch_cnt != 3'h0) begin
                s_d.stretch_cnt = s_q.stretch_cnt - 3'h1;
            end else begin
                s_d.e_phase = 1'b0;
                e_fall = 1'b1;
            end
            s_d.bus_clock_oe = s_q.bus_clk_en;
            s_d.bus_clock_out = s_d.e_phase && s_q.bus_clk_en;
        end
        s_d.bus_cycle = e_fall;

        // reset pin sequencer
        s_d.reset_pin_out = 1'b0;
        case (s_q.rseq)
            rst_idle: begin
                if (clock_monitor_fail || watchdog_fail) begin
                    s_d.rseq = rst_drive;
                    s_d.rcnt = 5'h0;
                    s_d.reset_pin_oe = 1'b1;
                    if (clock_monitor_fail) begin
                        s_d.src = vec_clock_monitor;
                        ev_set[`RCIP_EVT_CLK_MON] = 1'b1;
                    end else begin
                        s_d.src = vec_watchdog;
                        ev_set[`RCIP_EVT_WATCHDOG] = 1'b1;
                    end
                end else if (!s_q.rpin_level) begin
                    s_d.vec = vec_external;
                    s_d.rseq = rst_hold;
                    ev_set[`RCIP_EVT_EXT_RST] = 1'b1;
                end
            end
            rst_drive: begin
                s_d.rcnt = s_q.rcnt + 5'h1;
                if (s_q.rcnt == `RCIP_DRIVE_CYCLES - 5'h1) begin
                    s_d.reset_pin_oe = 1'b0;
                    s_d.rcnt = 5'h0;
                    s_d.rseq = rst_wait;
                end
            end
            rst_wait: begin
                s_d.rcnt = s_q.rcnt + 5'h1;
                if (s_q.rcnt == `RCIP_SAMPLE_DELAY - 5'h1) begin
                    s_d.rcnt = 5'h0;
                    if (s_q.rpin_level) begin
                        s_d.vec = s_q.src;
                        s_d.rseq = rst_idle;
                    end else begin
                        // an external source still holds the pin
                        s_d.vec = vec_external;
                        s_d.rseq = rst_hold;
                        ev_set[`RCIP_EVT_EXT_RST] = 1'b1;
                    end
                end
            end
            rst_hold: begin
                if (s_q.rpin_level) begin
                    s_d.rseq = rst_idle;
                end
            end
            default: begin
                s_d.rseq = rst_idle;
                s_d.reset_pin_oe = 1'b0;
            end
        endcase

        // maskable interrupt pin
        irq_fall = s_q.irq_level && !s_d.irq_level;
        if (irq_ack) begin
            s_d.irq_edge_latch = 1'b0;
        end
        if (irq_fall) begin
            s_d.irq_edge_latch = 1'b1;
            ev_set[`RCIP_EVT_IRQ_FALL] = 1'b1;
        end
        if (s_q.edge_sel) begin
            s_d.irq_request = s_d.irq_edge_latch && !s_q.imask;
        end else begin
            s_d.irq_request = !s_d.irq_level && !s_q.imask;
        end

        // a fresh event wins over a clearing read in the same cycle
        s_d.evt_status = (s_q.evt_status & ~ev_clr) | ev_set;
        s_d.irq_out = |(s_d.evt_status & s_d.evt_mask);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.irq_sync <= 3'h7;
            s_q.irq_level <= 1'b1;
            s_q.rpin_sync <= 3'h7;
            s_q.rpin_level <= 1'b1;
            s_q.stop <= `RCIP_RST_STOP;
            s_q.stretch <= `RCIP_RST_STRETCH;
            s_q.edge_sel <= `RCIP_RST_EDGE_SEL;
            s_q.imask <= `RCIP_RST_IMASK;
            s_q.evt_mask <= `RCIP_RST_EVT_MASK;
            s_q.rseq <= rst_idle;
            s_q.vec <= vec_external;
            s_q.src <= vec_external;
        end else begin
            s_q <= s_d;
        end
    end

    reset_release_sync u_release (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .reset_pin_in(reset_pin_in),
        .core_reset_b(core_reset_b)
    );

    assign axil_rsp = s_q.rsp;
    assign bus_clock_out = s_q.bus_clock_out;
    assign bus_clock_oe = s_q.bus_clock_oe;
    assign bus_cycle = s_q.bus_cycle;
    assign reset_pin_out = s_q.reset_pin_out;
    assign reset_pin_oe = s_q.reset_pin_oe;
    assign reset_vector_sel = s_q.vec;
    assign irq_request = s_q.irq_request;
    assign irq_out = s_q.irq_out;

endmodule : reset_clock_irq_pin_control

// File: rtl/reset_release_sync.sv
`timescale 1ns/1ps

module reset_release_sync (
    // clock and block reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // reset pin level and released core reset
    input wire logic reset_pin_in,
    output logic core_reset_b
);
    logic [2:0] chain_q;

    // entry needs no clock edge, so a dead oscillator still resets the core
    always_ff @(posedge clk_sys or negedge reset_pin_in) begin
        if (!reset_pin_in) begin
            chain_q <= 3'h0;
        end else if (!rst_b) begin
            chain_q <= 3'h0;
        end else begin
            chain_q <= {chain_q[1:0], 1'b1};
        end
    end

    assign core_reset_b = chain_q[2];

endmodule : reset_release_sync

// File: verif/board_model.sv
`timescale 1ns/1ps

module board_model (
    // clock and device pin drive
    input wire logic clk_sys,
    input wire logic reset_pin_oe,
    // bench commands
    input wire logic ext_rst_req,
    input wire logic irq_low,
    input wire logic per_clk,
    // pins seen by the device
    output logic reset_pin_in,
    output logic irq_pin_in,
    output logic bus_clock_in
);
    int rst_cnt = 0;
    logic [1:0] div_q = 2'h0;

    always @(posedge clk_sys) begin
        // held well past the minimum so the external vector always wins
        if (ext_rst_req) rst_cnt <= 40;
        else if (rst_cnt > 0) rst_cnt <= rst_cnt - 1;
        if (per_clk) div_q <= div_q + 2'h1;
    end
    // pulled up: low only while someone pulls it down
    assign reset_pin_in = !(reset_pin_oe || rst_cnt > 0);
    assign irq_pin_in = !irq_low;
    // stands still until the bench asks for it
    assign bus_clock_in = div_q[1];
endmodule : board_model

// File: verif/rcip_sva.sv
`timescale 1ns/1ps

module rcip_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register bus
    input wire rcip_pkg::axil_req_t axil_req,
    input wire rcip_pkg::axil_rsp_t axil_rsp,
    // bus clock pin
    input wire logic [1:0] mode_strap,
    input wire logic bus_clock_out,
    input wire logic bus_clock_oe,
    input wire logic ext_access,
    input wire logic bus_cycle,
    // reset pin
    input wire logic reset_pin_in,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic core_reset_b,
    input wire rcip_pkg::vector_t reset_vector_sel,
    input wire logic watchdog_fail,
    input wire logic clock_monitor_fail,
    // interrupt pin
    input wire logic irq_request
);
    import rcip_pkg::*;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_drive;
        reset_pin_oe [*8] ##1 reset_pin_oe [*8];
    endsequence
    sequence s_quiet;
        !irq_request [*8];
    endsequence

    a_drive_len: assert property (
        $rose(reset_pin_oe) |-> s_drive ##1 !reset_pin_oe)
        else $error("reset pin drive length wrong");
    a_drive_cause: assert property (
        $rose(reset_pin_oe) |-> $past(watchdog_fail || clock_monitor_fail))
        else $error("reset pin driven without a failure");
    a_open_drain: assert property (
        reset_pin_oe |-> !reset_pin_out)
        else $error("reset pin driven high");
    a_core_async: assert property (
        !reset_pin_in |-> !core_reset_b)
        else $error("core reset not cleared by pin");
    a_core_sync: assert property (
        $rose(core_reset_b) |-> $past(reset_pin_in) && $past(reset_pin_in, 2))
        else $error("core reset released too early");
    a_vec_fail: assert property (
        $changed(reset_vector_sel) && reset_vector_sel != vec_external
        |-> $past(reset_pin_in))
        else $error("failure vector with pin low");
    a_half_rate: assert property (
        $rose(bus_clock_out) && !ext_access && !$past(ext_access)
        |=> !bus_clock_out)
        else $error("bus clock high phase too long");
    a_cycle_fall: assert property (
        bus_cycle && bus_clock_oe && $past(bus_clock_oe)
        |-> $past(bus_clock_out) && !bus_clock_out)
        else $error("bus cycle pulse off the falling edge");
    a_periph_in: assert property (
        mode_strap == 2'h2 |-> !bus_clock_oe)
        else $error("bus clock driven in peripheral mode");
    a_irq_masked: assert property (
        $rose(rst_b) |-> s_quiet)
        else $error("interrupt request right after reset");
    a_rd_latency: assert property (
        axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
        else $error("read answer late");
endmodule : rcip_sva

bind reset_clock_irq_pin_control rcip_sva u_sva (.clk_sys, .rst_b,
    .axil_req, .axil_rsp, .mode_strap, .bus_clock_out, .bus_clock_oe,
    .ext_access, .bus_cycle, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
    .core_reset_b, .reset_vector_sel, .watchdog_fail, .clock_monitor_fail,
    .irq_request);

// File: verif/tb.sv
`timescale 1ns/1ps
`include "rcip_map.svh"

module tb;
    import rcip_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    axil_req_t rq = '0;
    axil_rsp_t rs;
    logic [1:0] mode_strap = 2'h0;
    logic ext_access = 1'b0;
    logic watchdog_fail = 1'b0;
    logic clock_monitor_fail = 1'b0;
    logic irq_ack = 1'b0;
    logic ext_rst_req = 1'b0;
    logic irq_low = 1'b0;
    logic per_clk = 1'b0;
    logic bus_clock_in, bus_clock_out, bus_clock_oe, bus_cycle;
    logic reset_pin_in, reset_pin_out, reset_pin_oe, core_reset_b;
    logic irq_pin_in, irq_request, irq_out;
    vector_t vsel;
    int fails = 0;
    int n_checks = 0;
    int hi, cy, ro;
    logic [1:0] qb[$];
    logic [33:0] qr[$];

    reset_clock_irq_pin_control dut (.clk_sys, .rst_b, .axil_req(rq),
        .axil_rsp(rs), .mode_strap, .bus_clock_in, .bus_clock_out,
        .bus_clock_oe, .ext_access, .bus_cycle, .reset_pin_in,
        .reset_pin_out, .reset_pin_oe, .core_reset_b,
        .reset_vector_sel(vsel), .watchdog_fail, .clock_monitor_fail,
        .irq_pin_in, .irq_ack, .irq_request, .irq_out);
    board_model brd (.clk_sys, .reset_pin_oe, .ext_rst_req, .irq_low,
        .per_clk, .reset_pin_in, .irq_pin_in, .bus_clock_in);

    initial forever #20 clk_sys = ~clk_sys;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [33:0] s, e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic rst(input logic [1:0] m);
        mode_strap <= m;
        rst_b <= 1'b0;
        cyc(16);
        rst_b <= 1'b1;
        cyc(2);
    endtask : rst

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = `RCIP_RESP_OKAY);
        int n;
        qb.push_back(er);
        @(posedge clk_sys);
        rq.awvalid <= 1'b1;
        rq.awaddr <= a;
        rq.wvalid <= 1'b1;
        rq.wdata <= d;
        rq.wstrb <= 4'hf;
        rq.bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
            if (rs.bvalid) break;
        end
        rq.bready <= 1'b0;
        if (n == 40) begin
            fails++;
            end_sim();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = `RCIP_RESP_OKAY);
        int n;
        qr.push_back({er, d});
        @(posedge clk_sys);
        rq.arvalid <= 1'b1;
        rq.araddr <= a;
        rq.rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            if (rs.arready) rq.arvalid <= 1'b0;
            if (rs.rvalid) break;
        end
        rq.rready <= 1'b0;
        if (n == 40) begin
            fails++;
            end_sim();
        end
    endtask : rd

    // counts bus clock highs, bus cycles and reset pin drive over n cycles
    task automatic meas(input int n);
        hi = 0;
        cy = 0;
        ro = 0;
        repeat (n) begin
            @(posedge clk_sys);
            hi += bus_clock_out;
            cy += bus_cycle;
            ro += reset_pin_oe;
        end
    endtask : meas

    // answers are judged here in issue order, away from the drivers
    always @(posedge clk_sys) begin
        if (rs.bvalid && rq.bready) chk("bresp", rs.bresp, qb.pop_front());
        if (rs.rvalid && rq.rready)
            chk("rdata", {rs.rresp, rs.rdata}, qr.pop_front());
    end

    initial begin
        int k;
        void'($urandom(98437));
        rst(2'h0);
        rd(`RCIP_OFS_CTRL, 32'h0);
        rd(`RCIP_OFS_IRQ_CTRL, 32'h0);
        rd(`RCIP_OFS_CCR, 32'h1);
        rd(`RCIP_OFS_EVT_MASK, 32'h0);
        rd(8'h3c, 32'h0, `RCIP_RESP_SLVERR);
        wr(8'h3c, $urandom, `RCIP_RESP_SLVERR);
        chk("oe", bus_clock_oe, 1'b0);
        wr(`RCIP_OFS_CTRL, 32'h1);
        cyc(3);
        chk("oe", bus_clock_oe, 1'b1);
        meas(16);
        chk("highs", hi, 8);
        ext_access <= 1'b1;
        wr(`RCIP_OFS_CTRL, 32'h11);
        cyc(4);
        meas(24);
        chk("highs", hi, 18);
        // stretch back to zero first, so dropping the access is harmless
        wr(`RCIP_OFS_CTRL, 32'h1);
        ext_access <= 1'b0;
        wr(`RCIP_OFS_CTRL, 32'h3);
        cyc(2);
        meas(16);
        chk("highs", hi, 0);
        chk("cycles", cy, 0);
        wr(`RCIP_OFS_CTRL, 32'h1);
        irq_low <= 1'b1;
        cyc(8 + $urandom % 8);
        chk("req", irq_request, 1'b0);
        wr(`RCIP_OFS_CCR, 32'h0);
        cyc(3);
        chk("req", irq_request, 1'b1);
        rd(`RCIP_OFS_PIN_STAT, 32'h42);
        irq_low <= 1'b0;
        cyc(8);
        chk("req", irq_request, 1'b0);
        rd(`RCIP_OFS_PIN_STAT, 32'h3);
        wr(`RCIP_OFS_IRQ_CTRL, 32'h1);
        // the level test above already latched a fall; clear it so the
        // edge test below cannot pass on that stale latch
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
        cyc(2);
        chk("req", irq_request, 1'b0);
        irq_low <= 1'b1;
        cyc(6 + $urandom % 8);
        irq_low <= 1'b0;
        cyc(8);
        chk("req", irq_request, 1'b1);
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
        cyc(2);
        chk("req", irq_request, 1'b0);
        chk("irq", irq_out, 1'b0);
        wr(`RCIP_OFS_EVT_MASK, 32'h1);
        cyc(2);
        chk("irq", irq_out, 1'b1);
        rd(`RCIP_OFS_EVT_STAT, 32'h1);
        cyc(2);
        chk("irq", irq_out, 1'b0);
        for (k = 0; k < 2; k++) begin
            if (k == 0) watchdog_fail <= 1'b1;
            else clock_monitor_fail <= 1'b1;
            @(posedge clk_sys);
            watchdog_fail <= 1'b0;
            clock_monitor_fail <= 1'b0;
            meas(20);
            chk("drive", ro, 16);
            cyc(12);
            chk("vec", vsel, k ? vec_clock_monitor : vec_watchdog);
            chk("core", core_reset_b, 1'b1);
        end
        // failure and external reset together: external must win
        ext_rst_req <= 1'b1;
        clock_monitor_fail <= 1'b1;
        @(posedge clk_sys);
        ext_rst_req <= 1'b0;
        clock_monitor_fail <= 1'b0;
        cyc(60);
        chk("vec", vsel, vec_external);
        rd(`RCIP_OFS_EVT_STAT, 32'he);
        // pin held low across reset release: the mask must still block it
        irq_low <= 1'b1;
        rst(2'h1);
        rd(`RCIP_OFS_CTRL, 32'h1);
        chk("req", irq_request, 1'b0);
        chk("oe", bus_clock_oe, 1'b1);
        wr(`RCIP_OFS_CTRL, 32'h0);
        cyc(2);
        chk("oe", bus_clock_oe, 1'b0);
        rst(2'h3);
        rd(`RCIP_OFS_CTRL, 32'h1);
        rd(`RCIP_OFS_PIN_STAT, 32'h32);
        rst(2'h2);
        per_clk <= 1'b1;
        meas(32);
        chk("oe", bus_clock_oe, 1'b0);
        chk("cycles", cy > 4, 1'b1);
        end_sim();
    end
endmodule : tb
